// ### hw/pwm_pkg.sv
// Constants and types for the bridge PWM output stage
// How it works
// - Direction change: unmodulated pair switches, modulated outputs blank last four counts.
// - Direction bit may be written any time; change waits until four counts before period end.
// - Three-bit source field picks which inputs may trigger shutdown.
// - Shutdown when interrupt pin is low or a chosen comparator is high.
// - Shutdown sets status bit; it stays until firmware or restart clears it.
// - Shutdown drives each enabled pair to its own safe state.
// - Shutdown is level based and lasts while the level stays.
// - Status writes are ignored while a hardware shutdown level is present.
// - After shutdown ends, waveform resumes only at next period start.
// - Writing one forces software shutdown; auto-restart clears it at once.
// - Auto-restart keeps status set while active, clears it when removed.
// - Half-bridge delays each rising edge by dead-band count instruction cycles.
// - Steering mode: mode upper bits 11, config 00, PWM on enabled pins.
// - In steering mode mode low bits choose pin polarity.
// - Shutdown in steering mode touches only pins carrying PWM.
// - Steering with sync clear applies right after the write.
// - Steering with sync set applies at next period start.
// - Timer flag sets as each new period begins, first at second.
// - Dead-band longer than duty keeps that output inactive all period.
// - Forward drives A, modulates D; reverse drives C, modulates B.
package pwm_pkg;
   localparam logic [7:0] OFS_CTRL  = 8'h00;
   localparam logic [7:0] OFS_SHUT  = 8'h04;
   localparam logic [7:0] OFS_DEAD  = 8'h08;
   localparam logic [7:0] OFS_STEER = 8'h0C;
   localparam logic [7:0] OFS_FLAG  = 8'h10;
   localparam logic [7:0] OFS_PER   = 8'h14;
   localparam logic [7:0] OFS_DUTY  = 8'h18;

   localparam int CTRL_DIR    = 7;
   localparam int CTRL_FULL   = 6;
   localparam int SHUT_STAT   = 7;
   localparam int DEAD_RSEN   = 7;
   localparam int STEER_SYNC  = 4;
   localparam int FLAG_TMR    = 0;

   localparam logic [7:0] CTRL_RST  = 8'h00;
   localparam logic [6:0] SHCTL_RST = 7'h00;
   localparam logic [7:0] DEAD_RST  = 8'h00;
   localparam logic [4:0] STEER_RST = 5'h01;
   localparam logic [7:0] PER_RST   = 8'hFF;
   localparam logic [7:0] DUTY_RST  = 8'h00;

   localparam int TOSC_NS     = 40;
   localparam int TCY_TOSC    = 4;
   localparam int TCY_CLKS    = (TCY_TOSC * TOSC_NS + TOSC_NS - 1) / TOSC_NS;
   localparam logic [8:0] DIR_BLANK_CNT = 9'h004;

   typedef enum logic [1:0] {
      CFG_SINGLE = 2'b00,
      CFG_FWD    = 2'b01,
      CFG_HALF   = 2'b10,
      CFG_REV    = 2'b11
   } out_cfg_t;

   typedef enum logic [1:0] {
      SAFE_LOW  = 2'b00,
      SAFE_HIGH = 2'b01,
      SAFE_HIZ  = 2'b10,
      SAFE_HIZ2 = 2'b11
   } safe_t;

   typedef enum logic [2:0] {
      ST_RUN  = 3'b001,
      ST_SHUT = 3'b010,
      ST_WAIT = 3'b100
   } run_st_t;
endpackage

// ### hw/sync_2ff.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module sync_2ff #(
   parameter int               WIDTH   = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= RST_VAL;
         q      <= RST_VAL;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule

// ### hw/dead_band.sv
// Rising-edge delay counted in instruction cycles
`timescale 1ns/1ps
module dead_band #(
   parameter int W = 7
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         tick,
   input  wire logic         din,
   input  wire logic [W-1:0] cnt,
   output logic              dout
);
   logic [W-1:0] wait_q;
   wire          done = (wait_q == cnt);

   // Count restarts whenever the input falls
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_q <= '0;
      end else if (!din) begin
         wait_q <= '0;
      end else if (tick && !done) begin
         wait_q <= wait_q + 1'b1;
      end
   end

   // Never reached within the pulse keeps output inactive
   assign dout = din && done;
endmodule

// ### hw/bridge_pwm.sv
// Bridge PWM output stage with shutdown, dead band and steering
//
// Our own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
module bridge_pwm (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   input  wire logic        ext_int_pin,
   input  wire logic [1:0]  comparator_output,
   output logic             pwm_out_a,
   output logic             pwm_out_b,
   output logic             pwm_out_c,
   output logic             pwm_out_d,
   output logic             pwm_oe_a,
   output logic             pwm_oe_b,
   output logic             pwm_oe_c,
   output logic             pwm_oe_d
);
   import pwm_pkg::*;

   // Pin inputs
   logic [2:0] pins_s;
   wire        int_s = pins_s[2];
   wire [1:0]  cmp_s = pins_s[1:0];

   sync_2ff #(
      .WIDTH   (3),
      .RST_VAL (3'h4)
   ) u_sync (
      .clk   (hclk),
      .rst_n (hresetn),
      .d     ({ext_int_pin, comparator_output}),
      .q     (pins_s)
   );

   // Registers
   logic [7:0] capture_compare_control_q;
   logic [6:0] shutdown_control_q;
   logic       shutdown_event_status_q;
   logic [7:0] dead_band_control_q;
   logic [4:0] steering_control_q;
   logic [3:0] steer_q;
   logic [7:0] per_q;
   logic [7:0] duty_q;
   logic       timer_period_flag_q;
   logic       dir_q;
   logic       blank_q;
   logic [7:0] tmr_q;
   logic [1:0] div_q;
   run_st_t    st_q;
   run_st_t    st_d;

   // Bus slave, zero wait states
   logic       wr_q;
   logic [7:0] wa_q;
   logic [31:0] hrdata_q;

   wire       hi_ok = (haddr[31:8] == 24'h000000);
   wire       acc   = hsel && htrans[1] && hready && hi_ok;
   wire [7:0] ra    = haddr[7:0];
   wire [7:0] wd    = hwdata[7:0];

   wire wsel_ctrl  = wr_q && (wa_q == OFS_CTRL);
   wire wsel_shut  = wr_q && (wa_q == OFS_SHUT);
   wire wsel_dead  = wr_q && (wa_q == OFS_DEAD);
   wire wsel_steer = wr_q && (wa_q == OFS_STEER);
   wire wsel_flag  = wr_q && (wa_q == OFS_FLAG);
   wire wsel_per   = wr_q && (wa_q == OFS_PER);
   wire wsel_duty  = wr_q && (wa_q == OFS_DUTY);

   // Field views
   wire [1:0] out_cfg    = capture_compare_control_q[7:6];
   wire [3:0] ccm_field  = capture_compare_control_q[3:0];
   wire       full       = capture_compare_control_q[CTRL_FULL];
   wire       dir_want   = capture_compare_control_q[CTRL_DIR];
   wire [2:0] shut_src   = shutdown_control_q[6:4];
   wire [1:0] pair_ac_safe_state = shutdown_control_q[3:2];
   wire [1:0] pair_bd_safe_state = shutdown_control_q[1:0];
   wire       auto_restart_enable = dead_band_control_q[DEAD_RSEN];
   wire [6:0] dead_band_count = dead_band_control_q[6:0];
   wire       pwm_on     = (ccm_field[3:2] == 2'b11);

   wire [7:0] flag_rd = {3'h0, (st_q == ST_RUN), blank_q, dir_q,
                         shutdown_event_status_q, timer_period_flag_q};
   wire [7:0] rd8 =
      (ra == OFS_CTRL)  ? capture_compare_control_q :
      (ra == OFS_SHUT)  ? {shutdown_event_status_q, shutdown_control_q} :
      (ra == OFS_DEAD)  ? dead_band_control_q :
      (ra == OFS_STEER) ? {3'h0, steering_control_q} :
      (ra == OFS_FLAG)  ? flag_rd :
      (ra == OFS_PER)   ? per_q :
      (ra == OFS_DUTY)  ? duty_q : 8'h00;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q     <= 1'b0;
         wa_q     <= 8'h00;
         hrdata_q <= 32'h0000_0000;
      end else begin
         wr_q <= acc && hwrite;
         if (acc) begin
            wa_q <= ra;
         end
         if (acc && !hwrite) begin
            hrdata_q <= {24'h000000, rd8};
         end
      end
   end

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_q;

   // Plain configuration registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         capture_compare_control_q <= CTRL_RST;
         shutdown_control_q        <= SHCTL_RST;
         dead_band_control_q       <= DEAD_RST;
         steering_control_q        <= STEER_RST;
         per_q                     <= PER_RST;
         duty_q                    <= DUTY_RST;
      end else begin
         if (wsel_ctrl) capture_compare_control_q <= wd;
         if (wsel_shut) shutdown_control_q <= wd[6:0];
         if (wsel_dead) dead_band_control_q <= wd;
         if (wsel_steer) steering_control_q <= wd[4:0];
         if (wsel_per) per_q <= wd;
         if (wsel_duty) duty_q <= wd;
      end
   end

   // Instruction-cycle tick and period timer
   wire tcy_en = (div_q == 2'(TCY_CLKS - 1));
   wire pstart = pwm_on && tcy_en && (tmr_q == per_q);
   wire pwm_raw = pwm_on && (tmr_q < duty_q);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_q <= 2'h0;
         tmr_q <= 8'h00;
      end else begin
         div_q <= tcy_en ? 2'h0 : div_q + 2'h1;
         if (!pwm_on) begin
            tmr_q <= 8'h00;
         end else if (tcy_en) begin
            tmr_q <= pstart ? 8'h00 : tmr_q + 8'h01;
         end
      end
   end

   // Period flag, set wins over clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         timer_period_flag_q <= 1'b0;
      end else if (pstart) begin
         timer_period_flag_q <= 1'b1;
      end else if (wsel_flag && wd[FLAG_TMR]) begin
         timer_period_flag_q <= 1'b0;
      end
   end

   // Direction change four counts before period end
   wire [8:0] tail_at  = {1'b0, per_q} - DIR_BLANK_CNT;
   wire       dir_pend = full && (dir_want != dir_q);
   wire       short_per = ({1'b0, per_q} < DIR_BLANK_CNT);
   wire       dir_trig = dir_pend && (short_per ? pstart :
                         (tcy_en && ({1'b0, tmr_q} == tail_at)));

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dir_q   <= 1'b0;
         blank_q <= 1'b0;
      end else begin
         if (!full || !pwm_on) begin
            dir_q <= dir_want;
         end else if (dir_trig) begin
            dir_q <= dir_want;
         end
         if (pstart || !full) begin
            blank_q <= 1'b0;
         end else if (dir_trig) begin
            blank_q <= 1'b1;
         end
      end
   end

   // Steering selection
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         steer_q <= STEER_RST[3:0];
      end else if (wsel_steer && !wd[STEER_SYNC]) begin
         steer_q <= wd[3:0];
      end else if (pstart && steering_control_q[STEER_SYNC]) begin
         steer_q <= steering_control_q[3:0];
      end
   end

   // Shutdown level and status bit
   wire shut_cond = (shut_src[0] && !int_s) ||
                    (shut_src[1] && cmp_s[0]) ||
                    (shut_src[2] && cmp_s[1]);
   wire hold = shut_cond || shutdown_event_status_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         shutdown_event_status_q <= 1'b0;
      end else if (shut_cond) begin
         shutdown_event_status_q <= 1'b1;
      end else if (wsel_shut) begin
         shutdown_event_status_q <= wd[SHUT_STAT];
      end else if (auto_restart_enable) begin
         shutdown_event_status_q <= 1'b0;
      end
   end

   always_comb begin
      st_d = st_q;
      case (st_q)
         ST_RUN:  if (hold) st_d = ST_SHUT;
         ST_SHUT: if (!hold) st_d = ST_WAIT;
         ST_WAIT: begin
            if (hold) begin
               st_d = ST_SHUT;
            end else if (pstart) begin
               st_d = ST_RUN;
            end
         end
         default: st_d = ST_WAIT;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q <= ST_WAIT;
      end else begin
         st_q <= st_d;
      end
   end

   wire shut_now = hold || (st_q != ST_RUN);

   // Half-bridge dead band on both edges' rising side
   logic [1:0] db;
   wire  [1:0] db_in = {!pwm_raw && pwm_on, pwm_raw};

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_db
         dead_band #(
            .W (7)
         ) u_db (
            .clk   (hclk),
            .rst_n (hresetn),
            .tick  (tcy_en),
            .din   (db_in[g]),
            .cnt   (dead_band_count),
            .dout  (db[g])
         );
      end
   endgenerate

   // Logical active levels, index 0..3 is A..D
   logic [3:0] act;
   logic [3:0] en;
   wire        mod = pwm_raw && !blank_q;

   always_comb begin
      act = 4'h0;
      en  = 4'hF;
      case (out_cfg)
         CFG_SINGLE: begin
            act = {4{pwm_raw}};
            en  = steer_q;
         end
         CFG_HALF: begin
            act = {2'b00, db[1], db[0]};
            en  = 4'h3;
         end
         default: begin
            if (dir_q) begin
               act = {1'b0, 1'b1, mod, 1'b0};
            end else begin
               act = {mod, 1'b0, 1'b0, 1'b1};
            end
         end
      endcase
   end

   // Polarity per pair: A/C from bit 1, B/D from bit 0
   wire [3:0] inv = {ccm_field[0], ccm_field[1], ccm_field[0], ccm_field[1]};
   wire [3:0] lvl = act ^ inv;

   logic [3:0] out_d;
   logic [3:0] oe_d;
   logic [3:0] out_q;
   logic [3:0] oe_q;

   generate
      for (g = 0; g < 4; g++) begin : g_pin
         wire [1:0] sf = (g % 2 == 0) ? pair_ac_safe_state
                                      : pair_bd_safe_state;
         wire safe_drv = (sf == SAFE_LOW) || (sf == SAFE_HIGH);
         assign oe_d[g] = pwm_on && en[g] && (!shut_now || safe_drv);
         assign out_d[g] = !pwm_on || !en[g] ? 1'b0 :
                           shut_now ? (sf == SAFE_HIGH) : lvl[g];
      end
   endgenerate

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         out_q <= 4'h0;
         oe_q  <= 4'h0;
      end else begin
         out_q <= out_d;
         oe_q  <= oe_d;
      end
   end

   assign pwm_out_a = out_q[0];
   assign pwm_out_b = out_q[1];
   assign pwm_out_c = out_q[2];
   assign pwm_out_d = out_q[3];
   assign pwm_oe_a  = oe_q[0];
   assign pwm_oe_b  = oe_q[1];
   assign pwm_oe_c  = oe_q[2];
   assign pwm_oe_d  = oe_q[3];

   // Checks
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   shut_set_a: assert property (shut_cond |=> shutdown_event_status_q)
      else $error("status not set by shutdown level");

   shut_wr_a: assert property (
      shut_cond && wsel_shut && !wd[SHUT_STAT] |=> shutdown_event_status_q)
      else $error("status cleared during shutdown level");

   restart_a: assert property (
      auto_restart_enable && !shut_cond && shutdown_event_status_q
      && !wsel_shut ##1 !shut_cond |-> !shutdown_event_status_q)
      else $error("auto restart did not clear status");

   level_a: assert property (hold |=> st_q != ST_RUN)
      else $error("ran while shutdown level present");

   resume_a: assert property (
      st_q == ST_WAIT && !pstart |=> st_q != ST_RUN)
      else $error("resumed before period start");

   safe_pin_a: assert property (
      hold && pwm_on && en[0] && pair_ac_safe_state ==
      SAFE_HIGH |=> pwm_oe_a && pwm_out_a)
      else $error("pair not in safe state");

   flag_a: assert property (pstart |=> timer_period_flag_q)
      else $error("period flag missing");

   steer_now_a: assert property (
      wsel_steer && !wd[STEER_SYNC] |=> steer_q == $past(wd[3:0]))
      else $error("steering not applied at once");

   steer_sync_a: assert property (
      wsel_steer && wd[STEER_SYNC] && !pstart |=> $stable(steer_q))
      else $error("synced steering changed early");

   dir_blank_a: assert property (
      dir_trig && !short_per |=> blank_q[*8])
      else $error("modulated outputs not blanked");

   steer_pins_a: assert property (
      pwm_on && out_cfg == CFG_SINGLE && !shut_now
      |=> {pwm_oe_d, pwm_oe_c, pwm_oe_b, pwm_oe_a} == $past(steer_q))
      else $error("steering enables not on pins");
endmodule

// ### tb/bridge_load.sv
// Model of the shutdown sources and the bridge pins
`timescale 1ns/1ps
module bridge_load (
   input  wire logic       int_fault,
   input  wire logic [1:0] cmp_fault,
   input  wire logic [3:0] out,
   input  wire logic [3:0] oe,
   output logic            ext_int_pin,
   output logic [1:0]      comparator_output,
   output logic [3:0]      pin
);
   // Interrupt line idles high, pulled low by a fault
   assign ext_int_pin       = ~int_fault;
   // Comparators report a fault as a high level
   assign comparator_output = cmp_fault;
   // Gate drives carry pull-downs: undriven pins read low
   assign pin               = out & oe;
endmodule

// ### tb/bridge_pwm_tb.sv
// Self-checking bench for the bridge PWM output stage
`timescale 1ns/1ps
module bridge_pwm_tb;
   import pwm_pkg::*;
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic        hreadyout;
   logic [31:0] hrdata;
   logic        hresp;
   logic        ext_int_pin;
   logic [1:0]  comparator_output;
   logic [3:0]  out;
   logic [3:0]  oe;
   logic [3:0]  pin;
   logic        int_fault;
   logic [1:0]  cmp_fault;
   logic [31:0] rd;
   logic [7:0]  sx [3] = '{8'h10, 8'h11, 8'h00};
   int          fb [2][4] = '{'{32, 0, 0, 12}, '{0, 12, 32, 0}};
   int          n_fail;
   int          checks;
   int          cnt;
   int          lo;

   bridge_pwm uut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
      .hresp(hresp), .ext_int_pin(ext_int_pin),
      .comparator_output(comparator_output),
      .pwm_out_a(out[0]), .pwm_out_b(out[1]), .pwm_out_c(out[2]),
      .pwm_out_d(out[3]), .pwm_oe_a(oe[0]), .pwm_oe_b(oe[1]),
      .pwm_oe_c(oe[2]), .pwm_oe_d(oe[3])
   );

   bridge_load load (
      .int_fault(int_fault), .cmp_fault(cmp_fault), .out(out), .oe(oe),
      .ext_int_pin(ext_int_pin), .comparator_output(comparator_output),
      .pin(pin)
   );

   initial begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end

   task automatic stop_test();
      if (n_fail == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   // One single-word transfer; read data lands in rd
   task automatic bus(input logic [7:0] a, input logic w,
                      input logic [31:0] d);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= {24'h000000, a};
      htrans <= 2'b10;
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
      hsel <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(a, 1'b1, d);
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      bus(a, 1'b0, 32'h0);
      chk(rd, exp);
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge hclk);
   endtask

   // High cycles of one pin over one period of 32 clocks
   task automatic pcnt(input int i);
      cnt = 0;
      repeat (32) begin
         @(posedge hclk);
         #1;
         cnt += int'(pin[i] === 1'b1);
      end
   endtask

   initial begin
      repeat (20000) @(posedge hclk);
      n_fail++;
      stop_test();
   end

   initial begin
      n_fail    = 0;
      checks    = 0;
      hresetn   = 1'b0;
      hsel      = 1'b0;
      haddr     = 32'h0;
      htrans    = 2'b00;
      hwrite    = 1'b0;
      hsize     = 3'h2;
      hwdata    = 32'h0;
      int_fault = 1'b0;
      cmp_fault = 2'b00;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      rchk(OFS_CTRL, 32'h00);
      rchk(OFS_SHUT, 32'h00);
      rchk(OFS_DEAD, 32'h00);
      rchk(OFS_STEER, 32'h01);
      rchk(OFS_PER, 32'hFF);
      rchk(OFS_DUTY, 32'h00);
      wr(8'h1C, 32'hFF);
      rchk(8'h1C, 32'h00);
      // Single output, period 8 counts, duty 3, B/D inverted
      wr(OFS_PER, 32'h07);
      wr(OFS_DUTY, 32'h03);
      wr(OFS_CTRL, 32'h0D);
      wr(OFS_STEER, 32'h03);
      idle(80);
      #1;
      chk({28'h0, oe}, 32'h3);
      pcnt(0);
      chk(32'(cnt), 32'd12);
      pcnt(1);
      chk(32'(cnt), 32'd20);
      @(posedge pin[0]);
      wr(OFS_STEER, 32'h14);
      #1;
      chk({28'h0, oe}, 32'h3);
      idle(40);
      #1;
      chk({28'h0, oe}, 32'h4);
      wr(OFS_STEER, 32'h01);
      idle(2);
      #1;
      chk({28'h0, oe}, 32'h1);
      // Shutdown from a source that is not selected, then from a selected one
      wr(OFS_SHUT, 32'h45);
      @(posedge hclk);
      cmp_fault <= 2'b01;
      idle(6);
      rchk(OFS_SHUT, 32'h45);
      for (int s = 0; s < 3; s++) begin
         wr(OFS_SHUT, 32'h20 | (s << 2));
         idle(5);
         #1;
         chk({24'h0, oe, pin}, {24'h0, sx[s]});
         wr(OFS_SHUT, 32'h20 | (s << 2));
         chk({30'h0, hreadyout, hresp}, 32'h2);
         rchk(OFS_SHUT, 32'hA0 | (s << 2));
      end
      idle(60);
      #1;
      chk({24'h0, oe, pin}, 32'h0);
      @(posedge hclk);
      cmp_fault <= 2'b00;
      idle(6);
      rchk(OFS_SHUT, 32'hA8);
      wr(OFS_SHUT, 32'h28);
      rchk(OFS_SHUT, 32'h28);
      idle(80);
      pcnt(0);
      chk(32'(cnt), 32'd12);
      // Auto-restart from the interrupt pin
      wr(OFS_DEAD, 32'h80);
      wr(OFS_SHUT, 32'h10);
      @(posedge hclk);
      int_fault <= 1'b1;
      idle(5);
      rchk(OFS_SHUT, 32'h90);
      @(posedge hclk);
      int_fault <= 1'b0;
      idle(5);
      rchk(OFS_SHUT, 32'h10);
      wr(OFS_SHUT, 32'h90);
      rchk(OFS_SHUT, 32'h10);
      idle(80);
      pcnt(0);
      chk(32'(cnt), 32'd12);
      @(posedge pin[0]);
      wr(OFS_FLAG, 32'h01);
      bus(OFS_FLAG, 1'b0, 32'h0);
      chk(rd & 32'h1, 32'h0);
      idle(32);
      bus(OFS_FLAG, 1'b0, 32'h0);
      chk(rd & 32'h1, 32'h1);
      // Full bridge, both directions
      wr(OFS_DEAD, 32'h00);
      for (int m = 0; m < 2; m++) begin
         wr(OFS_CTRL, m ? 32'hCC : 32'h4C);
         idle(80);
         for (int i = 0; i < 4; i++) begin
            pcnt(i);
            chk(32'(cnt), 32'(fb[m][i]));
         end
      end
      // Direction change at full duty
      wr(OFS_DUTY, 32'h08);
      wr(OFS_CTRL, 32'h4C);
      idle(80);
      wr(OFS_CTRL, 32'hCC);
      cnt = 0;
      lo  = 0;
      repeat (96) begin
         @(posedge hclk);
         #1;
         cnt += int'(pin[1] === 1'b0 && pin[3] === 1'b0);
         lo  += int'(pin[2] === 1'b1 && pin[0] === 1'b0 && pin[1] === 1'b0);
      end
      chk(32'(cnt), 32'd16);
      chk(32'(lo), 32'd16);
      pcnt(1);
      chk(32'(cnt), 32'd32);
      // Half bridge with dead band
      wr(OFS_DUTY, 32'h05);
      wr(OFS_CTRL, 32'h8C);
      idle(80);
      pcnt(0);
      chk(32'(cnt), 32'd20);
      pcnt(1);
      chk(32'(cnt), 32'd12);
      wr(OFS_DEAD, 32'h02);
      idle(80);
      pcnt(0);
      chk(32'(cnt >= 8 && cnt <= 16), 32'h1);
      pcnt(1);
      chk(32'(cnt < 12), 32'h1);
      wr(OFS_DEAD, 32'h06);
      idle(80);
      pcnt(0);
      chk(32'(cnt), 32'd0);
      stop_test();
   end
endmodule
